// ===== common/alb_pkg.sv
// Constants for the ancillary and top-line bypass block
// Function
// [RQ1] Ancillary pass setting forwards all ancillary content to the program output.
// [RQ2] Ancillary blank setting forwards no ancillary content to the program output.
// [RQ3] Bypass line count 0 to 5, effective only while ancillary is passed.
// [RQ4] Count zero sends every source-frame line, from line 20 or 23, to the scaler.
// [RQ5] Nonzero count x carries the first x source-frame lines directly to output.
// [RQ6] Bypassed lines are replaced by blanking before they reach the scaler.
// [RQ7] Input standard: auto detect, forced 525 or forced 625 picks the first line.
// [RQ8] Bypassed and ancillary content is delayed to match the scaler latency.
package alb_pkg;
    // ************************************************************
    // Widths and layout of the synchronised input bundle
    // ************************************************************
    localparam int DATA_W = 10;
    localparam int LINE_W = 10;
    localparam int CNT_W = 3;
    localparam int STD_W = 2;
    localparam int BUS_W = 20;
    localparam int POS_DATA = 0;
    localparam int POS_ANC = 10;
    localparam int POS_SOL = 11;
    localparam int POS_SOF = 12;
    localparam int POS_PASS = 13;
    localparam int POS_DET625 = 14;
    localparam int POS_CNT = 15;
    localparam int POS_STD = 18;
    // ************************************************************
    // Standards, line numbers, limits and blanking
    // ************************************************************
    localparam logic [STD_W-1:0] STD_AUTO = 2'h0;
    localparam logic [STD_W-1:0] STD_525 = 2'h1;
    localparam logic [STD_W-1:0] STD_625 = 2'h2;
    localparam logic [LINE_W-1:0] FIRST_LINE_525 = 10'h014;
    localparam logic [LINE_W-1:0] FIRST_LINE_625 = 10'h017;
    localparam logic [LINE_W-1:0] LINE_ONE = 10'h001;
    localparam logic [CNT_W-1:0] BYPASS_MAX = 3'h5;
    localparam logic [DATA_W-1:0] BLANK_LEVEL = 10'h040;
    // Scaler latency in video samples; the bypass delay line matches it
    localparam int SCL_LATENCY = 16;
endpackage

// ===== core/alb_bypass.sv
// Ancillary pass/blank and top-line bypass around the picture scaler
`timescale 1ns/1ns
module alb_bypass (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic vid_clk,
    input wire logic [9:0] vid_data,
    input wire logic vid_anc,
    input wire logic vid_sol,
    input wire logic vid_sof,
    input wire logic std_det_625,
    input wire logic [1:0] std_sel,
    input wire logic anc_pass,
    input wire logic [2:0] top_line_bypass_count,
    output logic [9:0] scl_in_data,
    output logic scl_in_valid,
    input wire logic [9:0] scl_out_data,
    output logic [9:0] out_data,
    output logic out_valid
);
    localparam int LAT = alb_pkg::SCL_LATENCY;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic vclk_s1_r;
    logic vclk_s2_r;
    logic vclk_s3_r;
    logic [alb_pkg::BUS_W-1:0] bus_s1_r;
    logic [alb_pkg::BUS_W-1:0] bus_s2_r;
    wire [alb_pkg::BUS_W-1:0] bus_raw = {std_sel, top_line_bypass_count, std_det_625,
        anc_pass, vid_sof, vid_sol, vid_anc, vid_data};

    // Two flops on every link and setting pin, a third on vid_clk; the edge detector reads the second and third stages
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vclk_s1_r <= 1'b0;
            vclk_s2_r <= 1'b0;
            vclk_s3_r <= 1'b0;
            bus_s1_r <= '0;
            bus_s2_r <= '0;
        end else begin
            vclk_s1_r <= vid_clk;
            vclk_s2_r <= vclk_s1_r;
            vclk_s3_r <= vclk_s2_r;
            bus_s1_r <= bus_raw;
            bus_s2_r <= bus_s1_r;
        end
    end

    // ************************************************************
    // Field decode of the synchronised bundle
    // ************************************************************
    // Data is launched on the falling link edge, so it is stable at the rising one
    wire samp_en = vclk_s2_r & ~vclk_s3_r;
    wire [9:0] in_data = bus_s2_r[alb_pkg::POS_DATA +: alb_pkg::DATA_W];
    wire in_anc = bus_s2_r[alb_pkg::POS_ANC];
    wire in_sol = bus_s2_r[alb_pkg::POS_SOL];
    wire in_sof = bus_s2_r[alb_pkg::POS_SOF];
    wire pass_q = bus_s2_r[alb_pkg::POS_PASS];
    wire det625_q = bus_s2_r[alb_pkg::POS_DET625];
    wire [2:0] cnt_q = bus_s2_r[alb_pkg::POS_CNT +: alb_pkg::CNT_W];
    wire [1:0] std_q = bus_s2_r[alb_pkg::POS_STD +: alb_pkg::STD_W];

    // Standard choice: forced values win, auto follows the detector
    wire is625 = (std_q == alb_pkg::STD_625) |
        ((std_q == alb_pkg::STD_AUTO) & det625_q); // see [RQ7]
    wire [9:0] first_line = is625 ? alb_pkg::FIRST_LINE_625
        : alb_pkg::FIRST_LINE_525; // see [RQ7]

    // Out-of-range counts clamp; count is ignored while ancillary is blanked
    wire [2:0] cnt_clamp = (cnt_q > alb_pkg::BYPASS_MAX) ? alb_pkg::BYPASS_MAX : cnt_q;
    wire [2:0] cnt_eff = pass_q ? cnt_clamp : 3'h0; // see [RQ3]

    // ************************************************************
    // Line counter
    // ************************************************************
    logic [9:0] line_r;
    wire [9:0] line_nxt = in_sof ? alb_pkg::LINE_ONE
        : (in_sol ? 10'(line_r + 10'h001) : line_r);

    // Frame start restarts at line one, each line start advances
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_r <= 10'h000;
        end else if (samp_en) begin
            line_r <= line_nxt;
        end
    end

    // Bypass window: first_line up to first_line + count - 1
    wire [9:0] win_end = 10'(first_line + {7'h00, cnt_eff});
    wire cur_byp = (line_nxt >= first_line) & (line_nxt < win_end); // see [RQ4] [RQ5]

    // ************************************************************
    // Scaler feed
    // ************************************************************
    // Bypassed lines must not leak into the scaled picture
    wire [9:0] scl_nxt = cur_byp ? alb_pkg::BLANK_LEVEL : in_data; // see [RQ6]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_in_data <= alb_pkg::BLANK_LEVEL;
            scl_in_valid <= 1'b0;
        end else begin
            scl_in_valid <= samp_en;
            if (samp_en) begin
                scl_in_data <= scl_nxt;
            end
        end
    end

    // ************************************************************
    // Latency-matching delay line for direct content
    // ************************************************************
    // Costs LAT words of storage, but keeps the merged raster line-aligned
    logic [9:0] dly_data_r [LAT];
    logic dly_anc_r [LAT];
    logic dly_byp_r [LAT];
    logic dly_pass_r [LAT];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_data_r[0] <= alb_pkg::BLANK_LEVEL;
            dly_anc_r[0] <= 1'b0;
            dly_byp_r[0] <= 1'b0;
            dly_pass_r[0] <= 1'b0;
        end else if (samp_en) begin
            dly_data_r[0] <= in_data;
            dly_anc_r[0] <= in_anc;
            dly_byp_r[0] <= cur_byp;
            dly_pass_r[0] <= pass_q;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi < LAT; gi++) begin : g_dly
            // One stage per video sample, see [RQ8]
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    dly_data_r[gi] <= alb_pkg::BLANK_LEVEL;
                    dly_anc_r[gi] <= 1'b0;
                    dly_byp_r[gi] <= 1'b0;
                    dly_pass_r[gi] <= 1'b0;
                end else if (samp_en) begin
                    dly_data_r[gi] <= dly_data_r[gi-1];
                    dly_anc_r[gi] <= dly_anc_r[gi-1];
                    dly_byp_r[gi] <= dly_byp_r[gi-1];
                    dly_pass_r[gi] <= dly_pass_r[gi-1];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Output merge
    // ************************************************************
    wire [9:0] tap_data = dly_data_r[LAT-1];
    wire tap_anc = dly_anc_r[LAT-1];
    wire tap_byp = dly_byp_r[LAT-1];
    wire tap_pass = dly_pass_r[LAT-1];
    // Ancillary follows the setting at its own arrival time, not the current one
    wire [9:0] anc_val = tap_pass ? tap_data : alb_pkg::BLANK_LEVEL; // see [RQ1] [RQ2]
    wire [9:0] out_nxt = tap_anc ? anc_val
        : (tap_byp ? tap_data : scl_out_data); // see [RQ5] [RQ8]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_data <= alb_pkg::BLANK_LEVEL;
            out_valid <= 1'b0;
        end else begin
            out_valid <= samp_en;
            if (samp_en) begin
                out_data <= out_nxt;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_anc_tap;
        samp_en && tap_anc;
    endsequence

    property p_anc_pass;
        @(posedge clk) disable iff (!arst_n)
        (s_anc_tap and tap_pass) |=> out_data == $past(tap_data);
    endproperty
    a_anc_pass: assert property (p_anc_pass) else $error("Ancillary not forwarded"); // see [RQ1]

    property p_anc_blank;
        @(posedge clk) disable iff (!arst_n)
        (s_anc_tap and !tap_pass) |=> out_data == alb_pkg::BLANK_LEVEL;
    endproperty
    a_anc_blank: assert property (p_anc_blank) else $error("Ancillary leaked"); // see [RQ2]

    property p_cnt_range;
        @(posedge clk) disable iff (!arst_n)
        (cnt_eff <= alb_pkg::BYPASS_MAX) && (pass_q || !cur_byp);
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("Bypass count misused"); // see [RQ3]

    property p_zero_count;
        @(posedge clk) disable iff (!arst_n)
        (cnt_q == 3'h0) |-> !cur_byp;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("Line bypassed at count 0"); // see [RQ4]

    property p_byp_direct;
        @(posedge clk) disable iff (!arst_n)
        (samp_en && !tap_anc && tap_byp) |=> out_valid && out_data == $past(tap_data);
    endproperty
    a_byp_direct: assert property (p_byp_direct) else $error("Bypass line not direct"); // see [RQ5]

    property p_scl_blank;
        @(posedge clk) disable iff (!arst_n)
        (samp_en && cur_byp) |=> scl_in_valid && scl_in_data == alb_pkg::BLANK_LEVEL;
    endproperty
    a_scl_blank: assert property (p_scl_blank) else $error("Scaler saw bypass line"); // see [RQ6]

    property p_first_line;
        @(posedge clk) disable iff (!arst_n)
        (std_q == alb_pkg::STD_525) |-> first_line == alb_pkg::FIRST_LINE_525;
    endproperty
    a_first_line: assert property (p_first_line) else $error("Wrong first line"); // see [RQ7]

    property p_dly_align;
        @(posedge clk) disable iff (!arst_n)
        samp_en |=> (dly_data_r[1] == $past(dly_data_r[0])) ##1 !out_valid;
    endproperty
    a_dly_align: assert property (p_dly_align) else $error("Delay line slipped"); // see [RQ8]
endmodule

// ===== testbench/alb_src_model.sv
// Serial video source model driving the link side of the bypass block
`timescale 1ns/1ns
module alb_src_model (
    input wire logic clk,
    output logic vid_clk,
    output logic [9:0] vid_data,
    output logic vid_anc,
    output logic vid_sol,
    output logic vid_sof
);
    // Idle link: clock parked low between frames
    initial begin
        vid_clk = 1'b0;
        vid_data = 10'h155;
        vid_anc = 1'b0;
        vid_sol = 1'b0;
        vid_sof = 1'b0;
    end

    // One frame, words launched on falling edges; sample 0 of each line is ancillary
    // Link period is 8 system clocks, all changes just after a rising clk edge
    task automatic send_frame(input int n_lines, input int spl);
        @(posedge clk);
        for (int l = 1; l <= n_lines; l++) begin
            for (int s = 0; s < spl; s++) begin
                vid_data <= {l[5:0], s[1:0], 2'h3};
                vid_anc <= (s == 0);
                vid_sof <= (l == 1 && s == 0);
                vid_sol <= (l > 1 && s == 0);
                repeat (4) @(posedge clk);
                vid_clk <= 1'b1;
                repeat (4) @(posedge clk);
                vid_clk <= 1'b0;
            end
        end
        // Released data inverts so a stale word can never look valid
        vid_data <= ~vid_data;
        vid_sof <= 1'b0;
        vid_sol <= 1'b0;
        vid_anc <= 1'b0;
    endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the ancillary and top-line bypass block
`timescale 1ns/1ns
module testbench;
    logic clk, arst_n, vid_clk, vid_anc, vid_sol, vid_sof, std_det_625, anc_pass;
    logic scl_in_valid, out_valid, byp;
    logic [9:0] vid_data, scl_in_data, scl_out_data, out_data;
    logic [1:0] std_sel;
    logic [2:0] top_line_bypass_count;
    int line_no, first, cnt, nin, nout, nscl, n_fail, check_count;
    logic [10:0] exp_out_q[$];
    logic [10:0] exp_scl_q[$];

    alb_src_model src (.clk(clk), .vid_clk(vid_clk), .vid_data(vid_data), .vid_anc(vid_anc),
        .vid_sol(vid_sol), .vid_sof(vid_sof));

    alb_bypass dut (.clk(clk), .arst_n(arst_n), .vid_clk(vid_clk), .vid_data(vid_data),
        .vid_anc(vid_anc), .vid_sol(vid_sol), .vid_sof(vid_sof), .std_det_625(std_det_625),
        .std_sel(std_sel), .anc_pass(anc_pass), .top_line_bypass_count(top_line_bypass_count),
        .scl_in_data(scl_in_data), .scl_in_valid(scl_in_valid), .scl_out_data(scl_out_data),
        .out_data(out_data), .out_valid(out_valid));

    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Expected words per link sample; every scaler word is checked, ancillary too
    always @(posedge vid_clk) begin
        line_no = vid_sof ? 1 : line_no + (vid_sol ? 1 : 0);
        first = (std_sel == 2'h2 || (std_sel == 2'h0 && std_det_625)) ? 23 : 20;
        cnt = !anc_pass ? 0 : (top_line_bypass_count > 3'h5 ? 5 : top_line_bypass_count);
        byp = line_no >= first && line_no < first + cnt;
        exp_out_q.push_back(vid_anc ? {1'b0, anc_pass ? vid_data : alb_pkg::BLANK_LEVEL}
            : {1'b0, byp ? vid_data : scl_out_data});
        exp_scl_q.push_back({1'b0, byp ? alb_pkg::BLANK_LEVEL : vid_data});
        nin++;
    end

    // Outputs sampled mid-cycle, after the launching edge has settled
    always @(negedge clk) begin
        if (out_valid === 1'b1) begin
            if (nout >= alb_pkg::SCL_LATENCY) begin
                check(out_data, exp_out_q[nout - alb_pkg::SCL_LATENCY][9:0]);
            end
            nout++;
        end
        if (scl_in_valid === 1'b1) begin
            if (!exp_scl_q[nscl][10]) check(scl_in_data, exp_scl_q[nscl][9:0]);
            nscl++;
        end
    end

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Settings change only while the link is idle, then one frame runs
    task automatic run(input logic p, input logic [2:0] c, input logic [1:0] s, input logic d);
        @(posedge clk);
        anc_pass <= p;
        top_line_bypass_count <= c;
        std_sel <= s;
        std_det_625 <= d;
        repeat (10) @(posedge clk);
        src.send_frame(26, 4);
        $display("test done at %0t", $time);
    endtask

    task automatic t_pass_zero();
        run(1'b1, 3'h0, 2'h0, 1'b0);
    endtask
    task automatic t_blank();
        run(1'b0, 3'h3, 2'h0, 1'b0);
    endtask
    task automatic t_byp5_525();
        run(1'b1, 3'h5, 2'h1, 1'b1);
    endtask
    task automatic t_clamp_625();
        run(1'b1, 3'h7, 2'h2, 1'b0);
    endtask
    task automatic t_auto_625();
        run(1'b1, 3'h2, 2'h0, 1'b1);
    endtask
    task automatic t_code3();
        run(1'b1, 3'h1, 2'h3, 1'b1);
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        anc_pass = 1'b1;
        top_line_bypass_count = 3'h0;
        std_sel = 2'h0;
        std_det_625 = 1'b0;
        scl_out_data = 10'h2aa;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_pass_zero();
        t_blank();
        t_byp5_525();
        t_clamp_625();
        t_auto_625();
        t_code3();
        t_pass_zero();
        for (int i = 0; i < 200 && (nscl < nin || nout < nin); i++) @(posedge clk);
        if (nscl != nin) begin
            n_fail++;
            $display("[ERR] %0t scaler words missing", $time);
        end
        if (nout != nin) begin
            n_fail++;
            $display("[ERR] %0t output words missing", $time);
        end
        close_out();
    end
endmodule
